// ===== hdl/sysc_zc.sv
`timescale 1ns/1ps
module sysc_zc #(
    parameter int PULSE_CYC = sysc_pkg::SYSC_ZC_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic crossing,
    input wire logic pulse_mode,
    // Output level
    output logic level
);

    localparam logic [15:0] LAST_CYC = 16'(PULSE_CYC - 1);

    sysc_pkg::sysc_zc_state_t state_q;
    sysc_pkg::sysc_zc_state_t state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic level_q;
    logic level_d;

    // ------------------------------------------------------------
    // Toggle on each crossing, or pulse on a crossing while idle
    // ------------------------------------------------------------
    // Pulse mode forces the level low while idle, so a switch of mode never
    // leaves a stale high level from toggle mode on the pin
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        level_d = level_q;
        if (!pulse_mode) begin
            state_d = sysc_pkg::SYSC_ZC_IDLE;
            cnt_d = sysc_pkg::SYSC_ZC_CNT_RST;
            if (crossing) begin
                level_d = ~level_q;
            end
        end else begin
            case (state_q)
                sysc_pkg::SYSC_ZC_IDLE: begin
                    level_d = 1'b0;
                    if (crossing) begin
                        state_d = sysc_pkg::SYSC_ZC_HIGH;
                        cnt_d = sysc_pkg::SYSC_ZC_CNT_RST;
                        level_d = 1'b1;
                    end
                end
                sysc_pkg::SYSC_ZC_HIGH: begin
                    level_d = 1'b1;
                    if (cnt_q == LAST_CYC) begin
                        state_d = sysc_pkg::SYSC_ZC_IDLE;
                        cnt_d = sysc_pkg::SYSC_ZC_CNT_RST;
                        level_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
                default: begin
                    state_d = sysc_pkg::SYSC_ZC_IDLE;
                    cnt_d = sysc_pkg::SYSC_ZC_CNT_RST;
                    level_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sysc_pkg::SYSC_ZC_IDLE;
            cnt_q <= sysc_pkg::SYSC_ZC_CNT_RST;
            level_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;

    // Toggle mode flips the level on every crossing
    property p_toggle_flip;
        @(posedge clk) disable iff (!rst_n)
        (crossing && !pulse_mode) |=> (level != $past(level));
    endproperty
    a_toggle_flip: assert property (p_toggle_flip) else $error("level did not toggle");

    // Pulse mode raises the level on a crossing while idle
    property p_pulse_start;
        @(posedge clk) disable iff (!rst_n)
        (crossing && pulse_mode && (state_q == sysc_pkg::SYSC_ZC_IDLE)) |=> level;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

    // The pulse counter never passes its last cycle
    property p_pulse_width;
        @(posedge clk) disable iff (!rst_n)
        (state_q == sysc_pkg::SYSC_ZC_HIGH) |-> (cnt_q <= LAST_CYC);
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse too long");

endmodule

`timescale 1ns/1ps
// Operation
// - Pulse mode bit gives fixed pulses per crossing, else output toggles.
// - Zero-crossing disable bit releases the zero-crossing pin.
// - Channel 2 accumulation runs only while its bit is set, else cleared.
// - Channel 1 accumulation runs only while its bit is set, else cleared.
// - PWM output enabled only while its bit is set.
// - Reset field codes place first, second or both current ADCs in reset.
// - Shutdown field codes shut first, second or both current ADCs down.
// - Reference shutdown bit disables the internal voltage reference.
// - Each range byte right-shifts the matching output value.
// - One power byte scales both active and reactive power of its channel.
// - First bank holds power, current and voltage shifts; top byte zero.
// - Second bank holds power and current shifts; top and bottom bytes zero.
// - The two lowest configuration bits always read as zero.
module sysc_top #(
    parameter int ZC_PULSE_CYC = sysc_pkg::SYSC_ZC_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic reg_wr_en,
    input wire logic [1:0] reg_idx,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Zero-crossing sense and pin
    input wire logic zc_sense,
    output logic zero_crossing_pin,
    output logic zero_crossing_oe_b,
    // Control outputs
    output logic chan_a_accum_on,
    output logic chan_a_accum_clr,
    output logic chan_b_accum_on,
    output logic chan_b_accum_clr,
    output logic pwm_enable,
    output logic first_current_adc_rst,
    output logic second_current_adc_rst,
    output logic first_current_adc_shdn,
    output logic second_current_adc_shdn,
    output logic internal_ref_off,
    // Raw samples in
    input wire logic raw_load,
    input wire logic [2:0] raw_sel,
    input wire logic [31:0] raw_value,
    // Scaled outputs
    output logic [31:0] volt_out,
    output logic [31:0] chan_a_amp_out,
    output logic [31:0] chan_a_act_out,
    output logic [31:0] chan_a_react_out,
    output logic [31:0] chan_b_amp_out,
    output logic [31:0] chan_b_act_out,
    output logic [31:0] chan_b_react_out
);

    logic rst_meta_q;
    logic rst_sync_b;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [31:0] bank_a_q;
    logic [31:0] bank_a_d;
    logic [31:0] bank_b_q;
    logic [31:0] bank_b_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic sense_s1_q;
    logic sense_s2_q;
    logic sense_s3_q;
    logic sense_stable_q;
    logic sense_stable_d;
    logic crossing;
    logic zc_level;

    // Only implemented bits survive a write
    function automatic logic [31:0] keep_bits(input logic [31:0] val, input logic [31:0] mask);
        return val & mask;
    endfunction

    // One shift byte out of a bank
    function automatic logic [7:0] shift_byte(input logic [31:0] bank, input int pos);
        return bank[pos +: 8];
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Reset asserts at once but releases on the clock to avoid a
    // half-released bank
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_b <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    // Writes are masked so unimplemented bits stay zero
    always_comb begin
        cfg_d = cfg_q;
        bank_a_d = bank_a_q;
        bank_b_d = bank_b_q;
        if (reg_wr_en) begin
            case (reg_idx)
                sysc_pkg::SYSC_IDX_CONFIG: begin
                    cfg_d = keep_bits(reg_wdata, sysc_pkg::SYSC_CONFIG_MASK);
                end
                sysc_pkg::SYSC_IDX_BANK_A: begin
                    bank_a_d = keep_bits(reg_wdata, sysc_pkg::SYSC_BANK_A_MASK);
                end
                sysc_pkg::SYSC_IDX_BANK_B: begin
                    bank_b_d = keep_bits(reg_wdata, sysc_pkg::SYSC_BANK_B_MASK);
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is registered; the index reads one cycle later
    always_comb begin
        case (reg_idx)
            sysc_pkg::SYSC_IDX_CONFIG: begin
                rdata_d = cfg_q;
            end
            sysc_pkg::SYSC_IDX_BANK_A: begin
                rdata_d = bank_a_q;
            end
            sysc_pkg::SYSC_IDX_BANK_B: begin
                rdata_d = bank_b_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cfg_q <= sysc_pkg::SYSC_CONFIG_RST;
            bank_a_q <= sysc_pkg::SYSC_BANK_RST;
            bank_b_q <= sysc_pkg::SYSC_BANK_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            cfg_q <= cfg_d;
            bank_a_q <= bank_a_d;
            bank_b_q <= bank_b_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Zero-crossing sense
    // ------------------------------------------------------------
    // The sense pin is asynchronous; a change counts once two late stages agree
    always_comb begin
        sense_stable_d = sense_stable_q;
        if (sense_s2_q == sense_s3_q) begin
            sense_stable_d = sense_s3_q;
        end
        crossing = (sense_stable_d != sense_stable_q);
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sense_s1_q <= 1'b0;
            sense_s2_q <= 1'b0;
            sense_s3_q <= 1'b0;
            sense_stable_q <= 1'b0;
        end else begin
            sense_s1_q <= zc_sense;
            sense_s2_q <= sense_s1_q;
            sense_s3_q <= sense_s2_q;
            sense_stable_q <= sense_stable_d;
        end
    end

    sysc_zc #(
        .PULSE_CYC(ZC_PULSE_CYC)
    ) zc_u (
        .clk(clk),
        .rst_n(rst_sync_b),
        .crossing(crossing),
        .pulse_mode(cfg_q[sysc_pkg::SYSC_POS_ZC_PULSE]),
        .level(zc_level)
    );

    // Output enable is low while the pin is driven
    assign zero_crossing_pin = zc_level;
    assign zero_crossing_oe_b = cfg_q[sysc_pkg::SYSC_POS_ZC_OFF];

    // ------------------------------------------------------------
    // Control outputs straight from configuration flops
    // ------------------------------------------------------------
    assign chan_b_accum_on = cfg_q[sysc_pkg::SYSC_POS_ACC_B];
    assign chan_b_accum_clr = ~cfg_q[sysc_pkg::SYSC_POS_ACC_B];
    assign chan_a_accum_on = cfg_q[sysc_pkg::SYSC_POS_ACC_A];
    assign chan_a_accum_clr = ~cfg_q[sysc_pkg::SYSC_POS_ACC_A];
    assign pwm_enable = cfg_q[sysc_pkg::SYSC_POS_PWM];
    assign first_current_adc_rst = cfg_q[sysc_pkg::SYSC_POS_ADC_RST];
    assign second_current_adc_rst = cfg_q[sysc_pkg::SYSC_POS_ADC_RST + 1];
    assign first_current_adc_shdn = cfg_q[sysc_pkg::SYSC_POS_ADC_SHDN];
    assign second_current_adc_shdn = cfg_q[sysc_pkg::SYSC_POS_ADC_SHDN + 1];
    assign internal_ref_off = cfg_q[sysc_pkg::SYSC_POS_REF_OFF];

    // ------------------------------------------------------------
    // Output scaling
    // ------------------------------------------------------------
    // Powers are signed and shifted arithmetically; RMS values never go negative
    sysc_shift volt_u (
        .clk(clk),
        .rst_n(rst_sync_b),
        .load(raw_load && (raw_sel == sysc_pkg::SYSC_SEL_VOLT)),
        .arith(1'b0),
        .din(raw_value),
        .count(shift_byte(bank_a_q, sysc_pkg::SYSC_POS_VOLT)),
        .dout(volt_out)
    );

    sysc_shift amp_a_u (
        .clk(clk),
        .rst_n(rst_sync_b),
        .load(raw_load && (raw_sel == sysc_pkg::SYSC_SEL_AMP_A)),
        .arith(1'b0),
        .din(raw_value),
        .count(shift_byte(bank_a_q, sysc_pkg::SYSC_POS_AMP)),
        .dout(chan_a_amp_out)
    );

    // Active and reactive share one power byte per channel
    sysc_shift act_a_u (
        .clk(clk),
        .rst_n(rst_sync_b),
        .load(raw_load && (raw_sel == sysc_pkg::SYSC_SEL_ACT_A)),
        .arith(1'b1),
        .din(raw_value),
        .count(shift_byte(bank_a_q, sysc_pkg::SYSC_POS_PWR)),
        .dout(chan_a_act_out)
    );

    sysc_shift react_a_u (
        .clk(clk),
        .rst_n(rst_sync_b),
        .load(raw_load && (raw_sel == sysc_pkg::SYSC_SEL_REACT_A)),
        .arith(1'b1),
        .din(raw_value),
        .count(shift_byte(bank_a_q, sysc_pkg::SYSC_POS_PWR)),
        .dout(chan_a_react_out)
    );

    sysc_shift amp_b_u (
        .clk(clk),
        .rst_n(rst_sync_b),
        .load(raw_load && (raw_sel == sysc_pkg::SYSC_SEL_AMP_B)),
        .arith(1'b0),
        .din(raw_value),
        .count(shift_byte(bank_b_q, sysc_pkg::SYSC_POS_AMP)),
        .dout(chan_b_amp_out)
    );

    sysc_shift act_b_u (
        .clk(clk),
        .rst_n(rst_sync_b),
        .load(raw_load && (raw_sel == sysc_pkg::SYSC_SEL_ACT_B)),
        .arith(1'b1),
        .din(raw_value),
        .count(shift_byte(bank_b_q, sysc_pkg::SYSC_POS_PWR)),
        .dout(chan_b_act_out)
    );

    sysc_shift react_b_u (
        .clk(clk),
        .rst_n(rst_sync_b),
        .load(raw_load && (raw_sel == sysc_pkg::SYSC_SEL_REACT_B)),
        .arith(1'b1),
        .din(raw_value),
        .count(shift_byte(bank_b_q, sysc_pkg::SYSC_POS_PWR)),
        .dout(chan_b_react_out)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cfg_low_zero;
        @(posedge clk) disable iff (!rst_sync_b)
        (reg_idx == sysc_pkg::SYSC_IDX_CONFIG) |=> (reg_rdata[1:0] == 2'h0);
    endproperty
    a_cfg_low_zero: assert property (p_cfg_low_zero) else $error("low config bits set");

    property p_bank_a_top;
        @(posedge clk) disable iff (!rst_sync_b)
        (reg_idx == sysc_pkg::SYSC_IDX_BANK_A) |=> (reg_rdata[31:24] == 8'h00);
    endproperty
    a_bank_a_top: assert property (p_bank_a_top) else $error("bank a top byte set");

    property p_bank_b_gaps;
        @(posedge clk) disable iff (!rst_sync_b)
        (reg_idx == sysc_pkg::SYSC_IDX_BANK_B) |=>
            ((reg_rdata[31:24] == 8'h00) && (reg_rdata[7:0] == 8'h00));
    endproperty
    a_bank_b_gaps: assert property (p_bank_b_gaps) else $error("bank b gap set");

    property p_cfg_write;
        @(posedge clk) disable iff (!rst_sync_b)
        (reg_wr_en && (reg_idx == sysc_pkg::SYSC_IDX_CONFIG)) |=>
            (cfg_q == ($past(reg_wdata) & sysc_pkg::SYSC_CONFIG_MASK));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write wrong");

    property p_accum_b;
        @(posedge clk) disable iff (!rst_sync_b)
        chan_b_accum_clr == !chan_b_accum_on;
    endproperty
    a_accum_b: assert property (p_accum_b) else $error("channel b clear wrong");

    property p_accum_a;
        @(posedge clk) disable iff (!rst_sync_b)
        chan_a_accum_clr == !chan_a_accum_on;
    endproperty
    a_accum_a: assert property (p_accum_a) else $error("channel a clear wrong");

    property p_zc_off;
        @(posedge clk) disable iff (!rst_sync_b)
        cfg_q[sysc_pkg::SYSC_POS_ZC_OFF] |-> zero_crossing_oe_b;
    endproperty
    a_zc_off: assert property (p_zc_off) else $error("pin driven while off");

endmodule

// ===== pkg/sysc_pkg.sv
package sysc_pkg;

    // ------------------------------------------------------------
    // Register indices on the command-link register port
    // ------------------------------------------------------------
    localparam logic [1:0] SYSC_IDX_CONFIG = 2'h0;
    localparam logic [1:0] SYSC_IDX_BANK_A = 2'h1;
    localparam logic [1:0] SYSC_IDX_BANK_B = 2'h2;

    // ------------------------------------------------------------
    // System configuration field positions
    // ------------------------------------------------------------
    localparam int SYSC_POS_ZC_PULSE = 11;
    localparam int SYSC_POS_ZC_OFF = 10;
    localparam int SYSC_POS_ACC_B = 9;
    localparam int SYSC_POS_ACC_A = 8;
    localparam int SYSC_POS_PWM = 7;
    localparam int SYSC_POS_ADC_RST = 5;
    localparam int SYSC_POS_ADC_SHDN = 3;
    localparam int SYSC_POS_REF_OFF = 2;

    // Writable bits; everything else reads as zero
    localparam logic [31:0] SYSC_CONFIG_MASK = 32'h0000_0ffc;
    localparam logic [31:0] SYSC_BANK_A_MASK = 32'h00ff_ffff;
    localparam logic [31:0] SYSC_BANK_B_MASK = 32'h00ff_ff00;
    localparam logic [31:0] SYSC_CONFIG_RST = 32'h0000_0000;
    localparam logic [31:0] SYSC_BANK_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Shift byte positions inside the two banks
    // ------------------------------------------------------------
    localparam int SYSC_POS_PWR = 16;
    localparam int SYSC_POS_AMP = 8;
    localparam int SYSC_POS_VOLT = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYSC_CLK_PERIOD_PS = 5000;
    localparam int SYSC_ZC_PULSE_US = 200;
    localparam int SYSC_ZC_PULSE_CYC = (SYSC_ZC_PULSE_US * 1000000) / SYSC_CLK_PERIOD_PS;

    localparam logic [15:0] SYSC_ZC_CNT_RST = 16'h0000;

    // ------------------------------------------------------------
    // Raw sample selectors on the scaling port
    // ------------------------------------------------------------
    localparam logic [2:0] SYSC_SEL_VOLT = 3'h0;
    localparam logic [2:0] SYSC_SEL_AMP_A = 3'h1;
    localparam logic [2:0] SYSC_SEL_ACT_A = 3'h2;
    localparam logic [2:0] SYSC_SEL_REACT_A = 3'h3;
    localparam logic [2:0] SYSC_SEL_AMP_B = 3'h4;
    localparam logic [2:0] SYSC_SEL_ACT_B = 3'h5;
    localparam logic [2:0] SYSC_SEL_REACT_B = 3'h6;

    // Zero-crossing pulse states
    typedef enum logic [1:0] {
        SYSC_ZC_IDLE = 2'b01,
        SYSC_ZC_HIGH = 2'b10
    } sysc_zc_state_t;

endpackage

// ===== hdl/sysc_shift.sv
`timescale 1ns/1ps
module sysc_shift (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sample in
    input wire logic load,
    input wire logic arith,
    input wire logic [31:0] din,
    input wire logic [7:0] count,
    // Scaled sample out
    output logic [31:0] dout
);

    logic [31:0] dout_q;
    logic [31:0] dout_d;

    // Divide by two to the count; signed powers keep their sign
    always_comb begin
        dout_d = dout_q;
        if (load) begin
            if (arith) begin
                dout_d = 32'($signed(din) >>> count);
            end else begin
                dout_d = din >> count;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_q <= 32'h0000_0000;
        end else begin
            dout_q <= dout_d;
        end
    end

    assign dout = dout_q;

    // Unsigned samples come out divided by two to the count
    property p_shift_result;
        @(posedge clk) disable iff (!rst_n)
        (load && !arith) |=> (dout == ($past(din) >> $past(count)));
    endproperty
    a_shift_result: assert property (p_shift_result) else $error("scaled value wrong");

endmodule

// ===== verif/sysc_host.sv
`timescale 1ns/1ps
// Host side: register port master, line sense and raw sample source
module sysc_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr_en,
    output logic [1:0] reg_idx,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // Line sense and raw samples
    output logic zc_sense,
    output logic raw_load,
    output logic [2:0] raw_sel,
    output logic [31:0] raw_value
);
    initial begin
        reg_wr_en = 1'b0;
        reg_idx = 2'h0;
        reg_wdata = 32'h0000_0000;
        zc_sense = 1'b0;
        raw_load = 1'b0;
        raw_sel = 3'h0;
        raw_value = 32'h0000_0000;
    end
    // Write lands at the rising edge between the two falling edges
    task automatic write(input logic [1:0] idx, input logic [31:0] val);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_idx = idx;
        reg_wdata = val;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask
    // Read data is registered, so take it one cycle after the index
    task automatic read(input logic [1:0] idx, output logic [31:0] val);
        @(negedge clk);
        reg_idx = idx;
        @(negedge clk);
        val = reg_rdata;
    endtask
    task automatic sample(input logic [2:0] sel, input logic [31:0] val);
        @(negedge clk);
        raw_load = 1'b1;
        raw_sel = sel;
        raw_value = val;
        @(negedge clk);
        raw_load = 1'b0;
    endtask
    task automatic flip_sense;
        @(negedge clk);
        zc_sense = ~zc_sense;
    endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk;
    logic rst_b = 1'b0;
    logic wr_en, sense, load, pin, oe_b, acc_a, clr_a, acc_b, clr_b, pwm, rst1, rst2;
    logic shd1, shd2, ref_off;
    logic [1:0] idx;
    logic [2:0] sel;
    logic [31:0] wdata, rdata, raw, volt, amp_a, act_a, react_a, amp_b, act_b, react_b;
    int failures = 0, comparisons = 0;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    sysc_host host_u (.clk(clk), .reg_wr_en(wr_en), .reg_idx(idx), .reg_wdata(wdata),
        .reg_rdata(rdata), .zc_sense(sense), .raw_load(load), .raw_sel(sel), .raw_value(raw));
    sysc_top #(.ZC_PULSE_CYC(4)) dut_u (.clk(clk), .rst_b(rst_b), .reg_wr_en(wr_en),
        .reg_idx(idx), .reg_wdata(wdata), .reg_rdata(rdata), .zc_sense(sense),
        .zero_crossing_pin(pin), .zero_crossing_oe_b(oe_b), .chan_a_accum_on(acc_a),
        .chan_a_accum_clr(clr_a), .chan_b_accum_on(acc_b), .chan_b_accum_clr(clr_b),
        .pwm_enable(pwm), .first_current_adc_rst(rst1), .second_current_adc_rst(rst2),
        .first_current_adc_shdn(shd1), .second_current_adc_shdn(shd2),
        .internal_ref_off(ref_off), .raw_load(load), .raw_sel(sel), .raw_value(raw),
        .volt_out(volt), .chan_a_amp_out(amp_a), .chan_a_act_out(act_a),
        .chan_a_react_out(react_a), .chan_b_amp_out(amp_b), .chan_b_act_out(act_b),
        .chan_b_react_out(react_b));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic test_reset_values;
        logic [31:0] v;
        host_u.read(2'h0, v);
        chk(v, 32'h0000_0000);
        host_u.read(2'h1, v);
        chk(v, 32'h0000_0000);
        host_u.read(2'h2, v);
        chk(v, 32'h0000_0000);
    endtask
    task automatic test_config;
        logic [31:0] v;
        host_u.write(2'h0, 32'hffff_ffff);
        host_u.read(2'h0, v);
        chk(v, 32'h0000_0ffc);
        chk({30'h0, acc_b, clr_b}, 32'h2);
        chk({30'h0, acc_a, clr_a}, 32'h2);
        chk({31'h0, pwm}, 32'h1);
        chk({30'h0, rst2, rst1}, 32'h3);
        chk({30'h0, shd2, shd1}, 32'h3);
        chk({31'h0, ref_off}, 32'h1);
        chk({31'h0, oe_b}, 32'h1);
        host_u.write(2'h0, 32'h0000_0020);
        chk({30'h0, rst2, rst1}, 32'h1);
        chk({30'h0, acc_a, clr_a}, 32'h1);
        host_u.write(2'h0, 32'h0000_0010);
        chk({30'h0, shd2, shd1}, 32'h2);
        chk({30'h0, rst2, rst1}, 32'h0);
        host_u.write(2'h0, 32'h0000_0000);
        chk({29'h0, pwm, ref_off, oe_b}, 32'h0);
    endtask
    task automatic test_banks;
        logic [31:0] v;
        host_u.write(2'h1, 32'hffff_ffff);
        host_u.read(2'h1, v);
        chk(v, 32'h00ff_ffff);
        host_u.write(2'h2, 32'hffff_ffff);
        host_u.read(2'h2, v);
        chk(v, 32'h00ff_ff00);
    endtask
    // Shift counts are kept small; only the voltage sample loses set bits (its low nibble)
    task automatic test_scale;
        host_u.write(2'h1, 32'h0002_0304);
        host_u.write(2'h2, 32'h0001_0500);
        host_u.sample(3'h0, 32'h8765_4321);
        chk(volt, 32'h0876_5432);
        host_u.sample(3'h1, 32'h0000_1000);
        chk(amp_a, 32'h0000_0200);
        host_u.sample(3'h2, 32'hffff_fff0);
        chk(act_a, 32'hffff_fffc);
        host_u.sample(3'h3, 32'h0000_0100);
        chk(react_a, 32'h0000_0040);
        host_u.sample(3'h4, 32'h0000_0400);
        chk(amp_b, 32'h0000_0020);
        host_u.sample(3'h5, 32'h0000_0010);
        chk(act_b, 32'h0000_0008);
        host_u.sample(3'h6, 32'h8000_0000);
        chk(react_b, 32'hc000_0000);
    endtask
    task automatic test_zc;
        host_u.flip_sense();
        repeat (5) @(negedge clk);
        chk({30'h0, pin, oe_b}, 32'h2);
        host_u.flip_sense();
        repeat (5) @(negedge clk);
        chk({31'h0, pin}, 32'h0);
        host_u.write(2'h0, 32'h0000_0800);
        host_u.flip_sense();
        repeat (5) @(negedge clk);
        chk({31'h0, pin}, 32'h1);
        repeat (5) @(negedge clk);
        chk({31'h0, pin}, 32'h0);
        host_u.write(2'h0, 32'h0000_0400);
        chk({31'h0, oe_b}, 32'h1);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        test_reset_values();
        test_config();
        test_banks();
        test_scale();
        test_zc();
        test_done();
    end
endmodule
